/* File: telecontrol_map.svh */
`ifndef TELECONTROL_MAP_SVH
`define TELECONTROL_MAP_SVH
// Register byte offsets
`define REG_CTRL        6'h00
`define REG_ADDR        6'h04
`define REG_PERIOD      6'h08
`define REG_STATUS      6'h0c
`define REG_EVENT       6'h10
`define REG_RX_CMD      6'h14
`define REG_TX_REPLY    6'h18
`define REG_TIME_SET    6'h1c
`define REG_DELAY       6'h20
`define REG_RECORDS     6'h24
`define REG_SCALE       6'h28
// Control fields
`define CTRL_BLOCK_LO   0
`define CTRL_MEDIA_BIT  2
`define CTRL_TEST_BIT   3
`define CTRL_EXTSYNC    4
`define CTRL_RESET      32'h0000_0000
// Address and period
`define ADDR_RESET      8'hff
`define ADDR_MAX        8'hfe
`define PERIOD_MIN      6'h01
`define PERIOD_MAX      6'h3c
`define PERIOD_RESET    6'h1e
// Frame type codes
`define ASDU_NACK       8'h01
`define ASDU_IDENT      8'h05
`define ASDU_MEAS       8'h09
`define ASDU_GI_END     8'h08
`define ASDU_TIME       8'h06
`define ASDU_CMD_NACK   8'h14
// Transmission cause codes
`define COT_SPONT       8'h01
`define COT_CYCLIC      8'h02
`define COT_FRAME_COUNT_RESET_CMD   8'h03
`define COT_COMM_UNIT_RESET_CMD    8'h04
`define COT_POWER_UP    8'h05
`define COT_TEST        8'h07
`define COT_TIME_SYNC   8'h08
`define COT_GI_END      8'h0a
`define COT_NACK        8'h14
`define COT_CONFIRM     8'h00
// Event codes
`define EV_NONE         8'h00
`define EV_POWER_UP     8'h01
`define EV_TIME_SYNC    8'h02
`define EV_TIME_REFUSE  8'h03
`define EV_TEST_ON      8'h04
`define EV_TEST_OFF     8'h05
// Scale: 2.4 as 10/24 on rated value
`define SCALE_NUM       16'h0018
`define SCALE_DEN       16'h000a
`define MAX_RECORDS     4'h8
`define CLK_HZ          32'd50000000
`define ONE_SECOND      32'd1
`define BROADCAST_ADDR  8'hff
`endif

/* File: telecontrol_pkg.sv */
package telecontrol_pkg;
  typedef enum logic [3:0] {
    CMD_NONE         = 4'h0,
    CMD_COMM_RESET   = 4'h1,
    CMD_FRAME_RESET  = 4'h2,
    CMD_TIME_SET     = 4'h3,
    CMD_GI           = 4'h4,
    CMD_REMOTE       = 4'h5,
    CMD_POLL_CLASS2  = 4'h6,
    CMD_READ_STATUS  = 4'h7,
    CMD_READ_RECORD  = 4'h8
  } cmd_e;
  typedef enum logic [1:0] {
    BLK_NONE    = 2'h0,
    BLK_MONITOR = 2'h1,
    BLK_COMMAND = 2'h2
  } block_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_REPLY = 3'b010,
    ST_EVENT = 3'b100
  } state_e;
endpackage : telecontrol_pkg

/* File: telecontrol_slave_responder.sv */
`timescale 1ns/1ns
`include "telecontrol_map.svh"
// Overview of operation
// - Link uninitialised until a reset command
// - Communication reset flushes transmit queue
// - Frame count reset keeps queued messages
// - Reset answered by ident with matching cause
// - Power-up event queued after initialisation
// - Confirm addressed time set, broadcast silent
// - Every time set raises class 1 event
// - Received time corrected by link delay
// - External sync refuses time set, logs event
// - Measurands published cyclically as type 9
// - Interval 1 to 60 s, immediate
// - Full scale equals 2.4 times rated
// - Unsupported command gets type 1 nack
// - Events on test mode entry and exit
// - Test mode tags events and measurements
// - At most 8 uncompressed disturbance records
// - Blocking select none, monitor, command, signals
// - Monitor blocking answers with GI termination
// - Command blocking answers command nack
// - Accept own link address 0..254 and broadcast address 255
// - Media change never applied: reset clears it before media_fibre loads
module telecontrol_slave_responder #(
  parameter int unsigned CLK_FREQ = 50000000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        monitor_block_sig,
  input  wire logic        command_block_sig,
  input  wire logic        comm_param_changed,
  input  wire logic        ext_time_sync,
  input  wire logic [31:0] ext_time,
  input  wire logic [15:0] rated_value,
  input  wire logic [3:0]  records_stored,
  output logic             meas_tick,
  output logic             media_fibre,
  output logic             tx_flush
);

  typedef struct packed {
    logic                    ack;
    logic [31:0]             rdata;
    logic                    linked;
    logic [7:0]              addr;
    logic [5:0]              period;
    logic [1:0]              block_sel;
    logic                    media_pend;
    logic                    media_act;
    logic                    media_loaded;
    logic                    test;
    logic [31:0]             clock_time;
    logic [31:0]             delay;
    logic [31:0]             sec_cnt;
    logic [5:0]              sec_elapsed;
    logic                    tick;
    logic                    flush;
    logic [7:0]              rep_type;
    logic [7:0]              rep_cot;
    logic                    rep_valid;
    logic [7:0]              ev_code;
    logic [7:0]              ev_cot;
    logic                    ev_valid;
    logic                    pu_pending;
    logic [15:0]             meas;
  } state_s;

  state_s cur_ff;
  state_s nxt_cur;

  function automatic logic [7:0] tag_cot(input logic test, input logic [7:0] transmission_cause);
    tag_cot = test ? `COT_TEST : transmission_cause;
  endfunction : tag_cot

  function automatic logic [5:0] clamp_period(input logic [5:0] p);
    if (p < `PERIOD_MIN) begin
      clamp_period = `PERIOD_MIN;
    end else if (p > `PERIOD_MAX) begin
      clamp_period = `PERIOD_MAX;
    end else begin
      clamp_period = p;
    end
  endfunction : clamp_period

  logic        acc;
  logic        wr;
  logic        mon_blk;
  logic        cmd_blk;
  logic [7:0]  rx_addr;
  logic [3:0]  rx_cmd;
  logic        rx_bcast;
  logic        addressed;
  logic [31:0] scaled;

  assign acc      = wb_cyc_i & wb_stb_i & ~cur_ff.ack;
  assign wr       = acc & wb_we_i;
  assign rx_addr  = wb_dat_i[15:8];
  assign rx_cmd   = wb_dat_i[3:0];
  assign rx_bcast = rx_addr == `BROADCAST_ADDR;
  assign addressed = rx_bcast | (rx_addr == cur_ff.addr && cur_ff.addr <= `ADDR_MAX);
  // Either the setting or an internal signal blocks, per selected direction
  assign mon_blk  = (cur_ff.block_sel == telecontrol_pkg::BLK_MONITOR) | monitor_block_sig;
  assign cmd_blk  = (cur_ff.block_sel == telecontrol_pkg::BLK_COMMAND) | command_block_sig;
  // Full scale is 2.4 x rated: code = rated * 10 / 24 of 16-bit range
  assign scaled   = (32'(rated_value) * 32'(`SCALE_DEN) * 32'h0000_ffff)
                    / (32'(rated_value) * 32'(`SCALE_NUM) + 32'h1);

  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.ack   = acc;
    nxt_cur.flush = 1'b0;
    nxt_cur.tick  = 1'b0;
    nxt_cur.rdata = 32'h0;
    nxt_cur.clock_time = cur_ff.clock_time;
    if (ext_time_sync) begin
      nxt_cur.clock_time = ext_time;
    end
    if (!cur_ff.media_loaded) begin
      nxt_cur.media_act    = cur_ff.media_pend;
      nxt_cur.media_loaded = 1'b1;
    end
    if (comm_param_changed) begin
      nxt_cur.linked = 1'b0;
    end
    // Measurement interval; a new period takes effect on the next second
    if (cur_ff.sec_cnt >= CLK_FREQ - 1) begin
      nxt_cur.sec_cnt = 32'h0;
      if (cur_ff.sec_elapsed + 6'h1 >= cur_ff.period) begin
        nxt_cur.sec_elapsed = 6'h0;
        nxt_cur.tick        = 1'b1;
        nxt_cur.meas        = scaled[15:0];
        if (cur_ff.linked && !mon_blk && !cur_ff.rep_valid) begin
          nxt_cur.rep_type  = `ASDU_MEAS;
          nxt_cur.rep_cot   = tag_cot(cur_ff.test, `COT_CYCLIC);
          nxt_cur.rep_valid = 1'b1;
        end
      end else begin
        nxt_cur.sec_elapsed = cur_ff.sec_elapsed + 6'h1;
      end
    end else begin
      nxt_cur.sec_cnt = cur_ff.sec_cnt + 32'h1;
    end
    if (cur_ff.pu_pending && !cur_ff.ev_valid) begin
      nxt_cur.ev_code    = `EV_POWER_UP;
      nxt_cur.ev_cot     = tag_cot(cur_ff.test, `COT_POWER_UP);
      nxt_cur.ev_valid   = 1'b1;
      nxt_cur.pu_pending = 1'b0;
    end
    if (acc && !wb_we_i) begin
      if (wb_adr_i == `REG_CTRL) begin
        nxt_cur.rdata = {27'h0, ext_time_sync, cur_ff.test, cur_ff.media_pend,
                         cur_ff.block_sel};
      end else if (wb_adr_i == `REG_ADDR) begin
        nxt_cur.rdata = {24'h0, cur_ff.addr};
      end else if (wb_adr_i == `REG_PERIOD) begin
        nxt_cur.rdata = {26'h0, cur_ff.period};
      end else if (wb_adr_i == `REG_STATUS) begin
        nxt_cur.rdata = {24'h0, cur_ff.media_act, mon_blk, cmd_blk, cur_ff.rep_valid,
                         cur_ff.ev_valid, cur_ff.test, ext_time_sync, cur_ff.linked};
      end else if (wb_adr_i == `REG_EVENT) begin
        nxt_cur.rdata    = {15'h0, cur_ff.ev_valid, cur_ff.ev_cot, cur_ff.ev_code};
        // Pop only a valid entry, so an event set in this cycle is kept
        if (cur_ff.ev_valid) begin
          nxt_cur.ev_valid = 1'b0;
        end
      end else if (wb_adr_i == `REG_TX_REPLY) begin
        nxt_cur.rdata     = {15'h0, cur_ff.rep_valid, cur_ff.rep_cot, cur_ff.rep_type};
        // A measurement queued in this cycle wins over the pop of an empty slot
        if (cur_ff.rep_valid) begin
          nxt_cur.rep_valid = 1'b0;
        end
      end else if (wb_adr_i == `REG_TIME_SET) begin
        nxt_cur.rdata = cur_ff.clock_time;
      end else if (wb_adr_i == `REG_DELAY) begin
        nxt_cur.rdata = cur_ff.delay;
      end else if (wb_adr_i == `REG_RECORDS) begin
        nxt_cur.rdata = {28'h0, (records_stored > `MAX_RECORDS) ? `MAX_RECORDS
                                                               : records_stored};
      end else if (wb_adr_i == `REG_SCALE) begin
        nxt_cur.rdata = {16'h0, cur_ff.meas};
      end
    end
    if (wr) begin
      if (wb_adr_i == `REG_CTRL) begin
        if (wb_sel_i[0]) begin
          nxt_cur.block_sel  = wb_dat_i[1:0] == 2'h3 ? 2'h0 : wb_dat_i[1:0];
          nxt_cur.media_pend = wb_dat_i[`CTRL_MEDIA_BIT];
          nxt_cur.test       = wb_dat_i[`CTRL_TEST_BIT];
          if (wb_dat_i[`CTRL_TEST_BIT] != cur_ff.test) begin
            nxt_cur.ev_code  = wb_dat_i[`CTRL_TEST_BIT] ? `EV_TEST_ON : `EV_TEST_OFF;
            nxt_cur.ev_cot   = `COT_SPONT;
            nxt_cur.ev_valid = 1'b1;
          end
        end
      end else if (wb_adr_i == `REG_ADDR) begin
        if (wb_sel_i[0] && wb_dat_i[7:0] <= `ADDR_MAX) begin
          nxt_cur.addr   = wb_dat_i[7:0];
          nxt_cur.linked = 1'b0;
        end
      end else if (wb_adr_i == `REG_PERIOD) begin
        if (wb_sel_i[0]) begin
          nxt_cur.period = clamp_period(wb_dat_i[5:0]);
        end
      end else if (wb_adr_i == `REG_DELAY) begin
        nxt_cur.delay = wb_dat_i;
      end else if (wb_adr_i == `REG_TIME_SET) begin
        nxt_cur.clock_time = wb_dat_i;
      end else if (wb_adr_i == `REG_RX_CMD && addressed) begin
        if (rx_cmd == telecontrol_pkg::CMD_COMM_RESET
            || rx_cmd == telecontrol_pkg::CMD_FRAME_RESET) begin
          nxt_cur.linked     = 1'b1;
          nxt_cur.pu_pending = 1'b1;
          nxt_cur.rep_type   = `ASDU_IDENT;
          nxt_cur.rep_cot    = rx_cmd == telecontrol_pkg::CMD_COMM_RESET ? `COT_COMM_UNIT_RESET_CMD
                                                                        : `COT_FRAME_COUNT_RESET_CMD;
          nxt_cur.rep_valid  = 1'b1;
          if (rx_cmd == telecontrol_pkg::CMD_COMM_RESET) begin
            nxt_cur.flush    = 1'b1;
            nxt_cur.ev_valid = 1'b0;
          end // frame count reset leaves the queue alone
        end else if (!cur_ff.linked) begin
          nxt_cur.rep_valid = cur_ff.rep_valid;
        end else if (rx_cmd == telecontrol_pkg::CMD_TIME_SET) begin
          if (ext_time_sync) begin
            nxt_cur.ev_code = `EV_TIME_REFUSE;
            nxt_cur.ev_cot  = tag_cot(cur_ff.test, `COT_SPONT);
          end else begin
            nxt_cur.clock_time = wb_dat_i[31:16] == 16'h0 ? cur_ff.clock_time + cur_ff.delay
                               : {wb_dat_i[31:16], 16'h0} + cur_ff.delay;
            nxt_cur.ev_code    = `EV_TIME_SYNC;
            nxt_cur.ev_cot     = tag_cot(cur_ff.test, `COT_TIME_SYNC);
          end
          nxt_cur.ev_valid = 1'b1;
          if (!rx_bcast) begin
            nxt_cur.rep_type  = `ASDU_TIME;
            nxt_cur.rep_cot   = `COT_CONFIRM;
            nxt_cur.rep_valid = 1'b1;
          end
        end else if ((rx_cmd == telecontrol_pkg::CMD_READ_STATUS
                      || rx_cmd == telecontrol_pkg::CMD_READ_RECORD
                      || rx_cmd == telecontrol_pkg::CMD_GI) && mon_blk) begin
          nxt_cur.rep_type  = `ASDU_GI_END;
          nxt_cur.rep_cot   = `COT_GI_END;
          nxt_cur.rep_valid = 1'b1;
        end else if (rx_cmd == telecontrol_pkg::CMD_REMOTE && cmd_blk) begin
          nxt_cur.rep_type  = `ASDU_CMD_NACK;
          nxt_cur.rep_cot   = `COT_NACK;
          nxt_cur.rep_valid = 1'b1;
        end else if (rx_cmd > telecontrol_pkg::CMD_READ_RECORD
                     || rx_cmd == telecontrol_pkg::CMD_NONE) begin
          nxt_cur.rep_type  = `ASDU_NACK;
          nxt_cur.rep_cot   = `COT_NACK;
          nxt_cur.rep_valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff              <= '0;
      cur_ff.addr         <= `ADDR_RESET;
      cur_ff.period       <= `PERIOD_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign wb_ack_o    = cur_ff.ack;
  assign wb_dat_o    = cur_ff.rdata;
  assign meas_tick   = cur_ff.tick;
  assign media_fibre = cur_ff.media_act;
  assign tx_flush    = cur_ff.flush;

endmodule : telecontrol_slave_responder

/* File: time_code_source.sv */
`timescale 1ns/1ns
// External time-code source: a free-running count, one step per clock cycle
module time_code_source (
  input  wire logic        clk,
  input  wire logic        rst_n,
  output logic      [31:0] ext_time
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ext_time <= 32'h0000_1000;
    else ext_time <= ext_time + 32'h1;
  end
endmodule : time_code_source

/* File: telecontrol_slave_responder_checker.sv */
`timescale 1ns/1ns
module telecontrol_slave_responder_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  records_stored,
  input wire logic        meas_tick,
  input wire logic        media_fibre,
  input wire logic        tx_flush
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] settle_ff;
  wire        rd_ack = wb_ack_o & !wb_we_i;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) settle_ff <= 2'h0;
    else if (settle_ff != 2'h3) settle_ff <= settle_ff + 2'h1;
  end
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  flush_pulse_a: assert property (tx_flush |=> !tx_flush) else $error("flush too long");
  tick_pulse_a: assert property (meas_tick |=> !meas_tick) else $error("tick too long");
  media_hold_a: assert property (settle_ff == 2'h3 |-> $stable(media_fibre))
    else $error("media changed without power-up");
  records_cap_a: assert property (rd_ack && wb_adr_i == 6'h24 && $stable(records_stored)
    |-> wb_dat_o == ((records_stored > 4'h8) ? 32'h8 : {28'h0, records_stored}))
    else $error("record count wrong");
  period_range_a: assert property (rd_ack && wb_adr_i == 6'h08
    |-> wb_dat_o >= 32'h1 && wb_dat_o <= 32'h3c) else $error("period out of range");
  block_code_a: assert property (rd_ack && wb_adr_i == 6'h00 |-> wb_dat_o[1:0] != 2'h3)
    else $error("illegal blocking code");
  flush_seen_c: cover property (tx_flush);
  tick_seen_c: cover property (meas_tick);
  records_read_c: cover property (rd_ack && wb_adr_i == 6'h24);
endmodule : telecontrol_slave_responder_checker
bind telecontrol_slave_responder telecontrol_slave_responder_checker chk (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .records_stored(records_stored), .meas_tick(meas_tick), .media_fibre(media_fibre),
  .tx_flush(tx_flush));

/* File: telecontrol_slave_responder_tb.sv */
`timescale 1ns/1ns
`include "telecontrol_map.svh"
module telecontrol_slave_responder_tb;
  logic clk, rst_n, cyc, stb, we, mon_blk, cmd_blk, param_chg, ext_sync;
  logic [5:0] adr;
  logic [31:0] wdat, rdat, ext_time, q;
  logic ack, tick, media, flush;
  logic [3:0] recs;
  int miscompares, n_compared, flushes;
  telecontrol_slave_responder #(.CLK_FREQ(1000)) dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .monitor_block_sig(mon_blk), .command_block_sig(cmd_blk),
    .comm_param_changed(param_chg), .ext_time_sync(ext_sync), .ext_time(ext_time),
    .rated_value(16'h0100), .records_stored(recs), .meas_tick(tick),
    .media_fibre(media), .tx_flush(flush));
  time_code_source src (.clk(clk), .rst_n(rst_n), .ext_time(ext_time));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (flush === 1'b1) flushes++;
  task end_of_test;
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      miscompares++;
      end_of_test();
    end
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Polls a popping register until a valid entry or the bound runs out
  task pop(input logic [5:0] a);
    for (int i = 0; i < 20; i++) begin
      wb(1'b0, a, 32'h0);
      if (q[16] === 1'b1) break;
    end
  endtask : pop
  task cmd(input logic [3:0] c, input logic [7:0] la, input logic [15:0] sec);
    wb(1'b1, `REG_RX_CMD, {sec, la, 4'h0, c});
  endtask : cmd
  task wait_tick(input int bound, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < bound);
    if (n >= bound) chk("tick", 32'h1, 32'h0);
  endtask : wait_tick
  task t_reset_values;
    wb(1'b0, `REG_CTRL, 0); chk("ctrl", 32'h0, q);
    wb(1'b0, `REG_ADDR, 0); chk("addr", 32'hff, q);
    wb(1'b0, `REG_PERIOD, 0); chk("period", 32'h1e, q);
    wb(1'b0, 6'h3c, 0); chk("unmapped", 32'h0, q);
    wb(1'b0, `REG_RECORDS, 0); chk("records", 32'h8, q);
    recs <= 4'h3;
    wb(1'b0, `REG_RECORDS, 0); chk("records few", 32'h3, q);
    wb(1'b1, `REG_CTRL, 32'h4); chk("media held", 32'h0, media);
    wb(1'b1, `REG_CTRL, 32'h0);
  endtask : t_reset_values
  task t_link;
    wb(1'b1, `REG_ADDR, 32'h21);
    cmd(4'h4, 8'h21, 16'h0); pop(`REG_TX_REPLY); chk("unlinked reply", 32'h0, q[16]);
    cmd(4'h2, 8'h21, 16'h0); pop(`REG_TX_REPLY);
    chk("fcb ident", {1'b1, `COT_FRAME_COUNT_RESET_CMD, `ASDU_IDENT}, q[16:0]);
    pop(`REG_EVENT); chk("power-up", `EV_POWER_UP, q[7:0]);
    chk("fcb flush", 32'h0, flushes);
    cmd(4'h1, 8'h21, 16'h0); pop(`REG_TX_REPLY);
    chk("cu ident", {1'b1, `COT_COMM_UNIT_RESET_CMD, `ASDU_IDENT}, q[16:0]);
    chk("cu flush", 32'h1, flushes);
    pop(`REG_EVENT); chk("power-up cu", `EV_POWER_UP, q[7:0]);
    wb(1'b0, `REG_STATUS, 0); chk("linked", 32'h1, q[0]);
    param_chg <= 1'b1; @(posedge clk); param_chg <= 1'b0; @(posedge clk);
    wb(1'b0, `REG_STATUS, 0); chk("unlinked", 32'h0, q[0]);
    cmd(4'h2, 8'h21, 16'h0); pop(`REG_TX_REPLY); pop(`REG_EVENT);
  endtask : t_link
  task t_time_and_nack;
    wb(1'b1, `REG_DELAY, 32'h5);
    cmd(4'h3, 8'h21, 16'h0100); pop(`REG_TX_REPLY); chk("confirm", 32'h1, q[16]);
    wb(1'b0, `REG_TIME_SET, 0); chk("delay fix", 32'h0100_0005, q);
    pop(`REG_EVENT); chk("sync ev", `EV_TIME_SYNC, q[7:0]);
    cmd(4'h3, `BROADCAST_ADDR, 16'h0200); pop(`REG_TX_REPLY); chk("bc", 32'h0, q[16]);
    pop(`REG_EVENT); chk("bc ev", `EV_TIME_SYNC, q[7:0]);
    ext_sync <= 1'b1;
    cmd(4'h3, 8'h21, 16'h0300); pop(`REG_EVENT); chk("refuse", `EV_TIME_REFUSE, q[7:0]);
    ext_sync <= 1'b0;
    pop(`REG_TX_REPLY);
    cmd(4'hf, 8'h22, 16'h0); pop(`REG_TX_REPLY); chk("foreign", 32'h0, q[16]);
    cmd(4'hf, 8'h21, 16'h0); pop(`REG_TX_REPLY);
    chk("nack", {1'b1, `COT_NACK, `ASDU_NACK}, q[16:0]);
  endtask : t_time_and_nack
  task t_blocking;
    logic [7:0] exp_code;
    for (int i = 0; i < 4; i++) begin
      mon_blk <= (i == 0); cmd_blk <= (i == 1);
      wb(1'b1, `REG_CTRL, (i == 2) ? 32'h1 : (i == 3) ? 32'h2 : 32'h0);
      exp_code = i[0] ? `ASDU_CMD_NACK : `ASDU_GI_END;
      cmd(i[0] ? 4'h5 : 4'h7, 8'h21, 16'h0); pop(`REG_TX_REPLY);
      chk("blocked code", exp_code, q[7:0]);
    end
    mon_blk <= 1'b0; cmd_blk <= 1'b0; wb(1'b1, `REG_CTRL, 32'h0);
  endtask : t_blocking
  task t_cyclic;
    int n;
    wb(1'b1, `REG_PERIOD, 32'h0); wb(1'b0, `REG_PERIOD, 0); chk("clamp lo", 32'h1, q);
    wb(1'b1, `REG_PERIOD, 32'h3d); wb(1'b0, `REG_PERIOD, 0); chk("clamp hi", 32'h3c, q);
    wb(1'b1, `REG_PERIOD, 32'h2);
    wait_tick(2100, n); wait_tick(2100, n); chk("interval", 32'd2000, n);
    wb(1'b0, `REG_SCALE, 0); chk("scale", 32'h1, q > 32'd27290 && q <= 32'd27307);
    pop(`REG_TX_REPLY); chk("meas", {1'b1, `COT_CYCLIC, `ASDU_MEAS}, q[16:0]);
    wb(1'b1, `REG_CTRL, 32'h8); pop(`REG_EVENT); chk("test on", `EV_TEST_ON, q[7:0]);
    wait_tick(2100, n); pop(`REG_TX_REPLY); chk("test meas", `COT_TEST, q[15:8]);
    cmd(4'h3, `BROADCAST_ADDR, 16'h0); pop(`REG_EVENT); chk("test ev", `COT_TEST, q[15:8]);
    wb(1'b1, `REG_CTRL, 32'h0); pop(`REG_EVENT); chk("test off", `EV_TEST_OFF, q[7:0]);
  endtask : t_cyclic
  initial begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 6'h0; wdat = 32'h0;
    mon_blk = 1'b0; cmd_blk = 1'b0; param_chg = 1'b0; ext_sync = 1'b0; recs = 4'hc;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_link();
    t_time_and_nack();
    t_blocking();
    t_cyclic();
    end_of_test();
  end
endmodule : telecontrol_slave_responder_tb
